// *** bench/ncrb_array_model.sv ***
/* memory array stand-in: answers each started operation except buffer clear with done pulses,
 * promptly or slowly. assumes arr_start is a one-cycle pulse on mclk. */
`timescale 1ns/100ps
`default_nettype none

module ncrb_array_model
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// operation
	input  wire logic       arr_start,
	input  wire logic [2:0] arr_code,
	input  wire logic       arr_to_eeprom,
	input  wire logic       arr_keep_eeprom,
	input  wire logic       slow,
	// completion
	output logic            flash_done,
	output logic            eeprom_done
);
	logic [5:0] cnt;
	logic       need_f;
	logic       need_e;

	always @(posedge mclk)
	begin
		flash_done  <= 1'b0;
		eeprom_done <= 1'b0;
		if (rst)
			cnt <= 6'h00;
		else if (arr_start)
		begin
			cnt    <= slow ? 6'h14 : 6'h02;
			need_e <= arr_code == 3'h6 || (arr_code == 3'h5 && !arr_keep_eeprom)
				|| (arr_code < 3'h4 && arr_to_eeprom);
			need_f <= arr_code == 3'h5 || arr_code == 3'h7 || (arr_code < 3'h4 && !arr_to_eeprom);
		end
		else if (cnt != 6'h00)
		begin
			cnt         <= cnt - 6'h01;
			flash_done  <= cnt == 6'h01 && need_f;
			eeprom_done <= cnt == 6'h01 && need_e;
		end
	end
endmodule : ncrb_array_model

`default_nettype wire

// *** bench/tb_top.sv ***
/* self-checking bench: commands, refusals, locks, interrupt and words.
 * assumes ncrb_pkg, the design and the array stand-in compile first. */
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import ncrb_pkg::*;
;
	logic        mclk, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, from_debug_port = 1'b0;
	logic        cpu_in_boot_section = 1'b0, self_program_key_open = 1'b1, ioreg_key_open = 1'b1;
	logic        eeprom_preserve_fuse = 1'b0, poweron_timeout_disable = 1'b1, slow = 1'b0;
	logic        buf_write_strobe = 1'b0, buf_mixed_sections = 1'b0, target_is_app = 1'b0;
	logic        target_is_eeprom = 1'b0, arr_start, arr_to_eeprom, arr_keep_eeprom;
	logic        buffer_clear, flash_done, eeprom_done;
	logic        boot_read_block, app_write_protect, eeprom_idle_irq;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, rv;
	logic [2:0]  arr_code;
	logic [15:0] buf_write_addr = 16'h0000, arr_addr, arr_data;
	int          n_fail, checks, cycles, n_bclr, b;

	ncrb_top #(.POR_TIMEOUT_CYCLES(8)) ncrb_top_i
	(
		.mclk, .rst, .reg_addr, .reg_we, .reg_re, .reg_wdata, .reg_rdata,
		.from_debug_port, .cpu_in_boot_section, .self_program_key_open,
		.ioreg_key_open, .eeprom_preserve_fuse, .poweron_timeout_disable,
		.buf_write_strobe, .buf_write_addr, .buf_mixed_sections, .target_is_eeprom,
		.target_is_app, .arr_start, .arr_code, .arr_to_eeprom, .arr_keep_eeprom,
		.arr_addr, .arr_data, .buffer_clear, .flash_done, .eeprom_done,
		.boot_read_block, .app_write_protect, .eeprom_idle_irq
	);

	ncrb_array_model ncrb_array_model_i
	(
		.mclk, .rst, .arr_start, .arr_code, .arr_to_eeprom, .arr_keep_eeprom,
		.slow, .flash_done, .eeprom_done
	);

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (buffer_clear === 1'b1)
			n_bclr <= n_bclr + 1;
		if (cycles == 20000)
		begin
			n_fail++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_we    <= 1'b1;
		@(posedge mclk);
		reg_we <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_re   <= 1'b1;
		@(posedge mclk);
		reg_re <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : rd

	task rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		rd(a);
		chk(what, {8'h00, exp}, {8'h00, rv});
	endtask : rchk

	task cmd(input logic [2:0] c, input logic go);
		wr(OFS_CMD, {5'h00, c});
		chk("arr_start", {15'h0, go}, {15'h0, arr_start});
		if (go)
			chk("arr_code", {13'h0, c}, {13'h0, arr_code});
	endtask : cmd

	// waits until both busy bits read zero before the next command
	task idle;
		rd(OFS_STATUS);
		for (int n = 0; n < 40 && rv[1:0] !== 2'b00; n++)
			rd(OFS_STATUS);
		chk("busy", 16'h0000, {14'h0, rv[1:0]});
	endtask : idle

	////////////////////////////////////////////////////////////////////////////
	task t_reset;
		rchk("por status", OFS_STATUS, 8'h03);
		cmd(CMD_BUF_CLEAR, 1'b0);
		rchk("por flag", OFS_IRQ_FLAG, 8'h00);
		for (int a = 0; a < 10; a++)
			if (a != 2 && a != 4)
				rchk("reset value", a[3:0], 8'h00);
		idle;
		@(posedge mclk);
		rst                     <= 1'b1;
		poweron_timeout_disable <= 1'b0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rchk("no por", OFS_STATUS, 8'h00);
	endtask : t_reset

	task t_cmds;
		b = n_bclr;
		for (int c = 1; c < 7; c++)
		begin
			@(posedge mclk);
			target_is_eeprom <= c[0];
			cmd(c[2:0], 1'b1);
			if (c < 4)
				chk("to_eeprom", {15'h0, c[0]}, {15'h0, arr_to_eeprom});
			idle;
		end
		chk("buffer clears", 16'h4, n_bclr[15:0] - b[15:0]);
		cmd(CMD_NONE, 1'b0);
		cmd(CMD_FUSE_WRITE, 1'b0);
		wr(OFS_DATA_LO, 8'ha5);
		wr(OFS_DATA_HI, 8'h5a);
		wr(OFS_ADDR_LO, 8'hc3);
		wr(OFS_ADDR_HI, 8'h3c);
		rchk("data hi", OFS_DATA_HI, 8'h5a);
		rchk("addr lo", OFS_ADDR_LO, 8'hc3);
		@(posedge mclk);
		from_debug_port <= 1'b1;
		cmd(CMD_FUSE_WRITE, 1'b1);
		chk("arr_data", 16'h5aa5, arr_data);
		chk("arr_addr", 16'h3cc3, arr_addr);
		idle;
		@(posedge mclk);
		from_debug_port  <= 1'b0;
		buf_write_strobe <= 1'b1;
		buf_write_addr   <= 16'h1234;
		@(posedge mclk);
		buf_write_strobe <= 1'b0;
		rchk("addr hi", OFS_ADDR_HI, 8'h12);
		rchk("addr lo", OFS_ADDR_LO, 8'h34);
	endtask : t_cmds

	task t_refuse;
		@(posedge mclk);
		self_program_key_open <= 1'b0;
		cmd(CMD_PAGE_WRITE, 1'b0);
		@(posedge mclk);
		self_program_key_open <= 1'b1;
		slow                  <= 1'b1;
		cmd(CMD_PAGE_ERASE, 1'b1);
		cmd(CMD_BUF_CLEAR, 1'b0);
		rchk("cmd reg", OFS_CMD, 8'h02);
		idle;
		@(posedge mclk);
		eeprom_preserve_fuse <= 1'b1;
		cmd(CMD_CHIP_ERASE, 1'b1);
		chk("keep eeprom", 16'h1, {15'h0, arr_keep_eeprom});
		rchk("chip keeps eeprom", OFS_STATUS, 8'h01);
		idle;
	endtask : t_refuse

	task t_irq;
		wr(OFS_IRQ_EN, 8'h01);
		@(posedge mclk);
		#1;
		chk("irq on", 16'h1, {15'h0, eeprom_idle_irq});
		wr(OFS_IRQ_FLAG, 8'h01);
		rchk("flag idle", OFS_IRQ_FLAG, 8'h01);
		cmd(CMD_EEPROM_WIPE, 1'b1);
		wr(OFS_IRQ_FLAG, 8'h01);
		rchk("flag busy", OFS_IRQ_FLAG, 8'h00);
		chk("irq cleared", 16'h0, {15'h0, eeprom_idle_irq});
		idle;
		rchk("flag again", OFS_IRQ_FLAG, 8'h01);
		wr(OFS_IRQ_EN, 8'h00);
		@(posedge mclk);
		#1;
		chk("irq off", 16'h0, {15'h0, eeprom_idle_irq});
	endtask : t_irq

	task t_locks;
		@(posedge mclk);
		slow           <= 1'b0;
		ioreg_key_open <= 1'b0;
		wr(OFS_LOCK, 8'h03);
		rchk("lock no key", OFS_LOCK, 8'h00);
		@(posedge mclk);
		ioreg_key_open <= 1'b1;
		wr(OFS_LOCK, 8'h03);
		rchk("lock outside boot", OFS_LOCK, 8'h01);
		wr(OFS_LOCK, 8'h00);
		chk("app protect", 16'h1, {15'h0, app_write_protect});
		@(posedge mclk);
		target_is_app <= 1'b1;
		cmd(CMD_PAGE_WRITE, 1'b0);
		rchk("fault protect", OFS_STATUS, 8'h04);
		@(posedge mclk);
		target_is_app      <= 1'b0;
		buf_mixed_sections <= 1'b1;
		cmd(CMD_PAGE_WRITE, 1'b0);
		rchk("fault mixed", OFS_STATUS, 8'h04);
		@(posedge mclk);
		buf_mixed_sections <= 1'b0;
		cmd(CMD_PAGE_WRITE, 1'b1);
		idle;
		rchk("fault gone", OFS_STATUS, 8'h00);
		@(posedge mclk);
		cpu_in_boot_section <= 1'b1;
		wr(OFS_LOCK, 8'h02);
		chk("boot early", 16'h0, {15'h0, boot_read_block});
		@(posedge mclk);
		cpu_in_boot_section <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("boot block", 16'h1, {15'h0, boot_read_block});
		wr(OFS_LOCK, 8'h00);
		rchk("locks held", OFS_LOCK, 8'h03);
	endtask : t_locks

	////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset;
		t_cmds;
		t_refuse;
		t_irq;
		t_locks;
		complete_run;
	end
endmodule : tb_top

`default_nettype wire

// *** design/ncrb_boot_lock.sv ***
/*
 * boot read lock: armed by a write, applied on first exit from boot code.
 * assumes in_boot is a same-clock level from the cpu fetch logic.
 */
`timescale 1ns/100ps
`default_nettype none

module ncrb_boot_lock
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// control
	input  wire logic lock_write,
	input  wire logic in_boot,
	// state
	output logic      lock_armed,
	output logic      lock_active
);

	logic armed_reg, armed_next;
	logic active_reg, active_next;
	logic boot_prev_reg;

	always_comb
	begin
		armed_next  = armed_reg | lock_write;
		active_next = active_reg | (armed_next & boot_prev_reg & ~in_boot);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			armed_reg     <= 1'b0;
			active_reg    <= 1'b0;
			boot_prev_reg <= 1'b0;
		end
		else
		begin
			armed_reg     <= armed_next;
			active_reg    <= active_next;
			boot_prev_reg <= in_boot;
		end
	end

	assign lock_armed  = armed_reg;
	assign lock_active = active_reg;

	AST_LOCK_ON_EXIT:
	assert property (@(posedge mclk) disable iff (rst)
		(armed_reg && boot_prev_reg && !in_boot) |=> lock_active)
	else $error("boot lock not applied on leaving boot code");

	AST_LOCK_NOT_EARLY:
	assert property (@(posedge mclk) disable iff (rst)
		(!active_reg && in_boot) |=> !lock_active)
	else $error("boot lock applied while still inside boot code");

endmodule : ncrb_boot_lock

`default_nettype wire

// *** design/ncrb_op_if.sv ***
/*
 * operation handshake between the register front end and the sequencer.
 * assumes both ends run on mclk.
 */
`timescale 1ns/100ps
`default_nettype none

interface ncrb_op_if;
	logic       start;
	logic [2:0] code;
	logic       to_eeprom;
	logic       keep_eeprom;
	logic       flash_busy;
	logic       eeprom_busy;
	logic       buf_clear;

	modport ctl (output start, code, to_eeprom, keep_eeprom,
	             input  flash_busy, eeprom_busy, buf_clear);
	modport seq (input  start, code, to_eeprom, keep_eeprom,
	             output flash_busy, eeprom_busy, buf_clear);
endinterface : ncrb_op_if

`default_nettype wire

// *** design/ncrb_op_seq.sv ***
/*
 * operation sequencer: tracks flash and eeprom busy per started command.
 * assumes the arrays pulse flash_done / eeprom_done once per operation.
 */
`timescale 1ns/100ps
`default_nettype none

module ncrb_op_seq
	import ncrb_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// front end
	ncrb_op_if.seq    op,
	// array completion
	input  wire logic flash_done,
	input  wire logic eeprom_done
);

	typedef enum logic [1:0] {S_IDLE, S_RUN, S_CLEAR} ncrb_seq_state_e;

	ncrb_seq_state_e state_reg, state_next;
	logic            fl_reg, fl_next;
	logic            ee_reg, ee_next;
	logic            page_reg, page_next;
	logic [2:0]      cnt_reg, cnt_next;
	logic            clr_reg, clr_next;

	always_comb
	begin
		state_next = state_reg;
		fl_next    = fl_reg;
		ee_next    = ee_reg;
		page_next  = page_reg;
		cnt_next   = cnt_reg;
		clr_next   = 1'b0;
		unique case (state_reg)
			S_IDLE:
			begin
				if (op.start)
				begin
					page_next = 1'b0;
					unique case (op.code)
						CMD_BUF_CLEAR:
						begin
							state_next = S_CLEAR;
							cnt_next   = BUF_CLEAR_CYCLES - 3'h1;
						end
						CMD_CHIP_ERASE:
						begin
							state_next = S_RUN;
							fl_next    = 1'b1;
							ee_next    = ~op.keep_eeprom;
						end
						CMD_EEPROM_WIPE:
						begin
							state_next = S_RUN;
							ee_next    = 1'b1;
						end
						CMD_FUSE_WRITE:
						begin
							state_next = S_RUN;
							fl_next    = 1'b1;
						end
						default:
						begin
							state_next = S_RUN;
							ee_next    = op.to_eeprom;
							fl_next    = ~op.to_eeprom;
							page_next  = 1'b1;
						end
					endcase
				end
			end
			S_RUN:
			begin
				if (flash_done)
					fl_next = 1'b0;
				if (eeprom_done)
					ee_next = 1'b0;
				if (!fl_next && !ee_next)
				begin
					state_next = S_IDLE;
					clr_next   = page_reg;
				end
			end
			S_CLEAR:
			begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0)
				begin
					state_next = S_IDLE;
					clr_next   = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_reg <= S_IDLE;
			fl_reg    <= 1'b0;
			ee_reg    <= 1'b0;
			page_reg  <= 1'b0;
			cnt_reg   <= 3'h0;
			clr_reg   <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			fl_reg    <= fl_next;
			ee_reg    <= ee_next;
			page_reg  <= page_next;
			cnt_reg   <= cnt_next;
			clr_reg   <= clr_next;
		end
	end

	assign op.flash_busy  = fl_reg | (state_reg == S_CLEAR);
	assign op.eeprom_busy = ee_reg;
	assign op.buf_clear   = clr_reg;

	AST_CHIP_KEEPS_EEPROM:
	assert property (@(posedge mclk) disable iff (rst)
		(state_reg == S_IDLE && op.start && op.code == CMD_CHIP_ERASE && op.keep_eeprom)
		|=> !op.eeprom_busy && op.flash_busy)
	else $error("chip erase touched eeprom although preserve was set");

	AST_PAGE_CLEARS_BUFFER:
	assert property (@(posedge mclk) disable iff (rst)
		(state_reg == S_RUN && page_reg && !fl_next && !ee_next) |=> op.buf_clear)
	else $error("page operation ended without a buffer clear");

endmodule : ncrb_op_seq

`default_nettype wire

// *** design/ncrb_pkg.sv ***
/*
 * constants for the nonvolatile command register bank: byte offsets,
 * field positions, command codes, reset values and cycle counts.
 * assumes byte-wide register access at the offsets below.
 */
package ncrb_pkg;

	// register byte offsets
	localparam logic [3:0] OFS_CMD      = 4'h0;
	localparam logic [3:0] OFS_LOCK     = 4'h1;
	localparam logic [3:0] OFS_STATUS   = 4'h2;
	localparam logic [3:0] OFS_IRQ_EN   = 4'h3;
	localparam logic [3:0] OFS_IRQ_FLAG = 4'h4;
	localparam logic [3:0] OFS_DATA_LO  = 4'h6;
	localparam logic [3:0] OFS_DATA_HI  = 4'h7;
	localparam logic [3:0] OFS_ADDR_LO  = 4'h8;
	localparam logic [3:0] OFS_ADDR_HI  = 4'h9;

	// field positions
	localparam int unsigned CMD_MSB          = 2;
	localparam int unsigned BIT_APP_WP       = 0;
	localparam int unsigned BIT_BOOT_LOCK    = 1;
	localparam int unsigned BIT_FLASH_BUSY   = 0;
	localparam int unsigned BIT_EEPROM_BUSY  = 1;
	localparam int unsigned BIT_WRITE_FAULT  = 2;
	localparam int unsigned BIT_EEPROM_IDLE  = 0;

	// command codes
	localparam logic [2:0] CMD_NONE        = 3'h0;
	localparam logic [2:0] CMD_PAGE_WRITE  = 3'h1;
	localparam logic [2:0] CMD_PAGE_ERASE  = 3'h2;
	localparam logic [2:0] CMD_ERASE_WRITE = 3'h3;
	localparam logic [2:0] CMD_BUF_CLEAR   = 3'h4;
	localparam logic [2:0] CMD_CHIP_ERASE  = 3'h5;
	localparam logic [2:0] CMD_EEPROM_WIPE = 3'h6;
	localparam logic [2:0] CMD_FUSE_WRITE  = 3'h7;

	// reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// cycle counts
	localparam logic [2:0]  BUF_CLEAR_CYCLES    = 3'h7;
	localparam int unsigned POR_TIMEOUT_DEFAULT = 4096;

endpackage : ncrb_pkg

// *** design/ncrb_top.sv ***
/*
 * nonvolatile command register bank: byte register port, command accept,
 * section locks, status, eeprom idle interrupt, data and address words.
 * assumes all inputs come from logic on mclk; rst is the power-on reset.
 */
`timescale 1ns/100ps
`default_nettype none

module ncrb_top
	import ncrb_pkg::*;
#(
	parameter int unsigned POR_TIMEOUT_CYCLES = POR_TIMEOUT_DEFAULT
)
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// access context
	input  wire logic        from_debug_port,
	input  wire logic        cpu_in_boot_section,
	input  wire logic        self_program_key_open,
	input  wire logic        ioreg_key_open,
	// fuses
	input  wire logic        eeprom_preserve_fuse,
	input  wire logic        poweron_timeout_disable,
	// page buffer and section map
	input  wire logic        buf_write_strobe,
	input  wire logic [15:0] buf_write_addr,
	input  wire logic        buf_mixed_sections,
	input  wire logic        target_is_eeprom,
	input  wire logic        target_is_app,
	// memory arrays
	output logic             arr_start,
	output logic      [2:0]  arr_code,
	output logic             arr_to_eeprom,
	output logic             arr_keep_eeprom,
	output logic      [15:0] arr_addr,
	output logic      [15:0] arr_data,
	output logic             buffer_clear,
	input  wire logic        flash_done,
	input  wire logic        eeprom_done,
	// protection and interrupt
	output logic             boot_read_block,
	output logic             app_write_protect,
	output logic             eeprom_idle_irq
);

	localparam int unsigned TW = $clog2(POR_TIMEOUT_CYCLES + 1);
	localparam logic [TW-1:0] TOUT_LAST = TW'(POR_TIMEOUT_CYCLES - 1);

	initial
	begin
		if (POR_TIMEOUT_CYCLES < 2)
			$error("POR_TIMEOUT_CYCLES must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////
	// submodules

	ncrb_op_if op ();

	logic lock_write;
	logic lock_armed;

	ncrb_op_seq u_seq (
		.mclk        (mclk),
		.rst         (rst),
		.op          (op),
		.flash_done  (flash_done),
		.eeprom_done (eeprom_done)
	);

	ncrb_boot_lock u_lock (
		.mclk        (mclk),
		.rst         (rst),
		.lock_write  (lock_write),
		.in_boot     (cpu_in_boot_section),
		.lock_armed  (lock_armed),
		.lock_active (boot_read_block)
	);

	////////////////////////////////////////////////////////////////////////
	// state

	logic [2:0]    cmd_reg, cmd_next;
	logic          start_reg, start_next;
	logic          to_ee_reg, to_ee_next;
	logic          keep_ee_reg, keep_ee_next;
	logic          app_wp_reg, app_wp_next;
	logic          fault_reg, fault_next;
	logic          irq_en_reg, irq_en_next;
	logic          irq_flag_reg, irq_flag_next;
	logic          irq_reg, irq_next;
	logic [15:0]   data_reg, data_next;
	logic [15:0]   addr_reg, addr_next;
	logic [7:0]    rdata_reg, rdata_next;
	logic          tout_reg, tout_next;
	logic [TW-1:0] tcnt_reg, tcnt_next;

	////////////////////////////////////////////////////////////////////////
	// decode

	logic       wr_cmd;
	logic [2:0] wr_code;
	logic       flash_busy_bit;
	logic       eeprom_busy_bit;
	logic       busy_any;
	logic       cmd_ok;
	logic       page_cmd;
	logic       fault;

	assign wr_cmd  = reg_we && (reg_addr == OFS_CMD);
	assign wr_code = reg_wdata[CMD_MSB:0];

	// a command just taken counts as busy until the sequencer owns it
	assign flash_busy_bit  = op.flash_busy | tout_reg | start_reg;
	assign eeprom_busy_bit = op.eeprom_busy | tout_reg | start_reg;
	assign busy_any        = flash_busy_bit | eeprom_busy_bit;

	assign cmd_ok = wr_cmd
		&& self_program_key_open
		&& !busy_any
		&& (wr_code != CMD_NONE)
		&& ((wr_code != CMD_FUSE_WRITE) || from_debug_port);

	assign page_cmd = (wr_code == CMD_PAGE_WRITE) || (wr_code == CMD_PAGE_ERASE)
		|| (wr_code == CMD_ERASE_WRITE);
	assign fault = page_cmd
		&& (buf_mixed_sections || (app_wp_reg && target_is_app));

	assign lock_write = reg_we && (reg_addr == OFS_LOCK) && ioreg_key_open
		&& reg_wdata[BIT_BOOT_LOCK] && cpu_in_boot_section;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		cmd_next      = cmd_reg;
		start_next    = 1'b0;
		to_ee_next    = to_ee_reg;
		keep_ee_next  = keep_ee_reg;
		app_wp_next   = app_wp_reg;
		fault_next    = fault_reg;
		irq_en_next   = irq_en_reg;
		irq_flag_next = irq_flag_reg;
		data_next     = data_reg;
		addr_next     = addr_reg;
		rdata_next    = rdata_reg;
		tout_next     = tout_reg;
		tcnt_next     = tcnt_reg;

		// power-on write refusal window
		if (tout_reg)
		begin
			tcnt_next = tcnt_reg + TW'(1);
			if (!poweron_timeout_disable || tcnt_reg == TOUT_LAST)
				tout_next = 1'b0;
		end

		if (cmd_ok)
		begin
			cmd_next     = wr_code;
			fault_next   = fault;
			start_next   = ~fault;
			to_ee_next   = target_is_eeprom;
			keep_ee_next = eeprom_preserve_fuse;
		end

		if (reg_we && reg_addr == OFS_LOCK && ioreg_key_open && reg_wdata[BIT_APP_WP])
			app_wp_next = 1'b1;
		if (reg_we && reg_addr == OFS_IRQ_EN)
			irq_en_next = reg_wdata[BIT_EEPROM_IDLE];

		// set while idle wins over a write-one clear
		if (!eeprom_busy_bit)
			irq_flag_next = 1'b1;
		else if (reg_we && reg_addr == OFS_IRQ_FLAG && reg_wdata[BIT_EEPROM_IDLE])
			irq_flag_next = 1'b0;
		irq_next = irq_en_next & irq_flag_next;

		if (reg_we && reg_addr == OFS_DATA_LO)
			data_next[7:0] = reg_wdata;
		if (reg_we && reg_addr == OFS_DATA_HI)
			data_next[15:8] = reg_wdata;
		if (reg_we && reg_addr == OFS_ADDR_LO)
			addr_next[7:0] = reg_wdata;
		if (reg_we && reg_addr == OFS_ADDR_HI)
			addr_next[15:8] = reg_wdata;
		// a buffer write overrides a same-cycle software write
		if (buf_write_strobe)
			addr_next = buf_write_addr;

		if (reg_re)
		begin
			unique case (reg_addr)
				OFS_CMD:      rdata_next = {5'h00, cmd_reg};
				OFS_LOCK:     rdata_next = {6'h00, lock_armed, app_wp_reg};
				OFS_STATUS:   rdata_next = {5'h00, fault_reg, eeprom_busy_bit,
				                            flash_busy_bit};
				OFS_IRQ_EN:   rdata_next = {7'h00, irq_en_reg};
				OFS_IRQ_FLAG: rdata_next = {7'h00, irq_flag_reg};
				OFS_DATA_LO:  rdata_next = data_reg[7:0];
				OFS_DATA_HI:  rdata_next = data_reg[15:8];
				OFS_ADDR_LO:  rdata_next = addr_reg[7:0];
				OFS_ADDR_HI:  rdata_next = addr_reg[15:8];
				default:      rdata_next = RST_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cmd_reg      <= CMD_NONE;
			start_reg    <= 1'b0;
			to_ee_reg    <= 1'b0;
			keep_ee_reg  <= 1'b0;
			app_wp_reg   <= 1'b0;
			fault_reg    <= 1'b0;
			irq_en_reg   <= 1'b0;
			irq_flag_reg <= 1'b0;
			irq_reg      <= 1'b0;
			data_reg     <= RST_WORD;
			addr_reg     <= RST_WORD;
			rdata_reg    <= RST_BYTE;
			tout_reg     <= 1'b1;
			tcnt_reg     <= '0;
		end
		else
		begin
			cmd_reg      <= cmd_next;
			start_reg    <= start_next;
			to_ee_reg    <= to_ee_next;
			keep_ee_reg  <= keep_ee_next;
			app_wp_reg   <= app_wp_next;
			fault_reg    <= fault_next;
			irq_en_reg   <= irq_en_next;
			irq_flag_reg <= irq_flag_next;
			irq_reg      <= irq_next;
			data_reg     <= data_next;
			addr_reg     <= addr_next;
			rdata_reg    <= rdata_next;
			tout_reg     <= tout_next;
			tcnt_reg     <= tcnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign op.start       = start_reg;
	assign op.code        = cmd_reg;
	assign op.to_eeprom   = to_ee_reg;
	assign op.keep_eeprom = keep_ee_reg;

	assign arr_start         = start_reg;
	assign arr_code          = cmd_reg;
	assign arr_to_eeprom     = to_ee_reg;
	assign arr_keep_eeprom   = keep_ee_reg;
	assign arr_addr          = addr_reg;
	assign arr_data          = data_reg;
	assign buffer_clear      = op.buf_clear;
	assign app_write_protect = app_wp_reg;
	assign eeprom_idle_irq   = irq_reg;
	assign reg_rdata         = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	AST_START_CARRIES_CODE:
	assert property (@(posedge mclk) disable iff (rst)
		(cmd_ok && !fault) |=> arr_start && arr_code == $past(wr_code))
	else $error("accepted command did not start with its code");

	AST_NO_KEY_NO_START:
	assert property (@(posedge mclk) disable iff (rst)
		(wr_cmd && !self_program_key_open) |=> !arr_start)
	else $error("command started without the key window");

	AST_FUSE_CPU_REFUSED:
	assert property (@(posedge mclk) disable iff (rst)
		(wr_cmd && wr_code == CMD_FUSE_WRITE && !from_debug_port) |=> !arr_start)
	else $error("fuse programming started from the cpu");

	AST_BUSY_IGNORED:
	assert property (@(posedge mclk) disable iff (rst)
		(wr_cmd && busy_any) |=> !arr_start && $stable(cmd_reg))
	else $error("command taken while busy");

	AST_FAULT_BLOCKS:
	assert property (@(posedge mclk) disable iff (rst)
		(cmd_ok && fault) |=> fault_reg && !arr_start ##1 !arr_start)
	else $error("faulty page command was not refused with fault set");

	AST_APP_WP_STICKY:
	assert property (@(posedge mclk) disable iff (rst)
		app_write_protect |=> app_write_protect [*3])
	else $error("app write protect cleared without reset");

	AST_TIMEOUT_BUSY:
	assert property (@(posedge mclk) disable iff (rst)
		tout_reg |-> flash_busy_bit && eeprom_busy_bit && !cmd_ok)
	else $error("writes possible during the power-on window");

	AST_IDLE_FLAG:
	assert property (@(posedge mclk) disable iff (rst)
		!eeprom_busy_bit |=> irq_flag_reg)
	else $error("eeprom idle flag not set while idle");

	AST_IRQ_LEVEL:
	assert property (@(posedge mclk) disable iff (rst)
		(irq_en_reg && irq_flag_reg) |-> eeprom_idle_irq)
	else $error("interrupt low with enable and flag set");

	AST_ADDR_TRACKS:
	assert property (@(posedge mclk) disable iff (rst)
		buf_write_strobe |=> arr_addr == $past(buf_write_addr))
	else $error("address word missed a buffer write");

endmodule : ncrb_top

`default_nettype wire
